// *** rtl/aodp_pkg.sv ***
// constants and types of the converter output processing block
package aodp_pkg;
   localparam int DW = 11;
   // register indices
   localparam logic [3:0] REG_CTRL  = 4'h0;
   localparam logic [3:0] REG_PROC  = 4'h1;
   localparam logic [3:0] REG_DRIVE = 4'h2;
   localparam logic [3:0] REG_STAT  = 4'h3;
   localparam logic [3:0] REG_OFS_A = 4'h4;
   localparam logic [3:0] REG_OFS_B = 4'h5;
   // control fields
   localparam int CTRL_TWOS = 0;
   localparam int CTRL_LVDS = 1;
   localparam int CTRL_LLAT = 2;
   localparam int CTRL_NSM  = 3;
   localparam int CTRL_PDN  = 4;
   localparam int PROC_GAIN = 0;
   localparam int PROC_TC   = 4;
   localparam int PROC_DCEN = 7;
   localparam int PROC_FRZ  = 8;
   localparam int DRV_CUR   = 0;
   localparam int DRV_DBL   = 2;
   localparam int DRV_ODT   = 3;
   // write masks and reset values
   localparam logic [15:0] CTRL_MASK  = 16'h007F;
   localparam logic [15:0] PROC_MASK  = 16'h01FF;
   localparam logic [15:0] DRIVE_MASK = 16'h003F;
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [15:0] PROC_RST   = 16'h0000;
   localparam logic [15:0] DRIVE_RST  = 16'h0000;
   // modes and codes
   localparam logic [2:0]  PDN_MUX     = 3'h7;
   localparam int          LAT_NORM    = 14;
   localparam int          LAT_LOW     = 10;
   localparam logic [3:0]  GAIN_MAXC   = 4'hA;
   localparam logic [13:0] GAIN_ONE    = 14'h1000;
   localparam int          GAIN_FRAC   = 12;
   localparam logic [11:0] OFS_LIM_DEF = 12'h00A;
   localparam logic signed [11:0] OB_MID  = 12'sh400;
   localparam logic signed [12:0] SAT_POS = 13'sh03FF;
   localparam logic signed [12:0] SAT_NEG = 13'sh1C00;
   localparam logic [5:0]  TC_DEF_SH   = 6'h1B;
   typedef enum logic [1:0] {
      CUR_3P5  = 2'b00,
      CUR_2P5  = 2'b01,
      CUR_4P5  = 2'b10,
      CUR_1P75 = 2'b11
   } aodp_cur_e;
   typedef struct packed {
      logic          ovr_pos;
      logic          ovr_neg;
      logic [DW-1:0] code;
   } aodp_smp_s;
endpackage

// *** rtl/aodp_top.sv ***
// output formatting, correction, latency and multiplex logic of the converter
// Notes on behaviour
// RULE_01 - format twos or offset binary, reg or strap
// RULE_02 - positive overdrive gives 0x7FF or 0x3FF
// RULE_03 - negative overdrive gives 0x000 or 0x400
// RULE_04 - multiplexed mode only with cmos interface
// RULE_05 - mux interleaves on bus b, a floats
// RULE_06 - system keeps mux mode below 65 msps
// RULE_07 - mux chosen by mode field or straps
// RULE_08 - field 111 or all straps high
// RULE_09 - latency 14 cycles, low latency 10
// RULE_10 - low latency bypasses whole processing chain
// RULE_11 - noise shaping mode bypasses filter stage; the code only reports filt_bypass in the status register, data path unchanged
// RULE_12 - offset loop estimates and subtracts per channel
// RULE_13 - time constant from three bit field
// RULE_14 - freeze holds last offset estimate
// RULE_15 - offset correction off after reset
// RULE_16 - fine gain 0.05 db steps to 0.5
// RULE_17 - one gain for both channels, positive
// RULE_18 - drive current select and current double
// RULE_19 - three termination resistors, any subset
// RULE_20 - corrected result saturates, never wraps
// RULE_21 - unused gain codes mean no gain
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module aodp_top
   import aodp_pkg::*;
#(
   parameter int          LAT_N   = LAT_NORM,
   parameter int          LAT_L   = LAT_LOW,
   parameter logic [11:0] OFS_LIM = OFS_LIM_DEF
)
(
   input  wire logic            core_clk,
   input  wire logic            resetn,
   input  wire logic [3:0]      reg_addr,
   input  wire logic [15:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [15:0]     reg_rdata,
   input  wire logic            sample_clk,
   input  wire aodp_smp_s       conv_a,
   input  wire aodp_smp_s       conv_b,
   input  wire logic            parallel_cfg_pin,
   input  wire logic            parallel_strap_pin,
   input  wire logic [2:0]      mode_strap_pins,
   output logic      [DW-1:0]   chan_a_out_bus,
   output logic                 chan_a_oe,
   output logic      [DW-1:0]   chan_b_out_bus,
   output logic                 chan_b_oe,
   output logic                 out_stb,
   output logic                 lvds_if_sel,
   output aodp_cur_e            lvds_cur_sel,
   output logic                 cur_double,
   output logic      [2:0]      odt_en
);

   logic [1:0]        lk_sync;
   logic              lk_prev;
   aodp_smp_s         smp_m [2];
   aodp_smp_s         smp_q [2];
   logic [4:0]        strap_m;
   logic [4:0]        strap_q;
   logic [15:0]       ctrl;
   logic [15:0]       proc_r;
   logic [15:0]       drive;
   logic [15:0]       next_ctrl;
   logic [15:0]       next_proc_r;
   logic [15:0]       next_drive;
   logic [15:0]       next_rdata;
   logic signed [41:0] acc [2];
   logic signed [41:0] next_acc [2];
   logic signed [11:0] est [2];
   logic [DW-1:0]     pipe_n [2][LAT_N];
   logic [DW-1:0]     pipe_l [2][LAT_L];
   logic [DW-1:0]     next_pipe_n [2][LAT_N];
   logic [DW-1:0]     next_pipe_l [2][LAT_L];
   logic [DW-1:0]     hold_b;
   logic [DW-1:0]     next_hold_b;
   logic [DW-1:0]     next_out_a;
   logic [DW-1:0]     next_out_b;
   logic              next_oe_a;
   logic              next_oe_b;
   logic              next_stb;
   logic              rise;
   logic              fall;
   logic              fmt_twos;
   logic              mux_req;
   logic              mux_on;
   logic              low_lat;
   logic              filt_bypass;
   logic              dc_en;
   logic              frz;
   logic [5:0]        tc_sh;
   logic [13:0]       gain;

   // offset loop time constant as a shift
   function automatic logic [5:0] tc_shift(input logic [2:0] sel);
      case (sel)
         3'h1:    tc_shift = 6'h1A;
         3'h2:    tc_shift = 6'h19;
         3'h3:    tc_shift = 6'h18;
         3'h4:    tc_shift = 6'h1C;
         3'h5:    tc_shift = 6'h1D;
         default: tc_shift = TC_DEF_SH;
      endcase
   endfunction

   // fine gain multiplier, 12 fraction bits
   function automatic logic [13:0] gain_q12(input logic [3:0] c);
      case (c)
         4'h1:    gain_q12 = 14'h1018;
         4'h2:    gain_q12 = 14'h102F;
         4'h3:    gain_q12 = 14'h1047;
         4'h4:    gain_q12 = 14'h105F;
         4'h5:    gain_q12 = 14'h1078;
         4'h6:    gain_q12 = 14'h1090;
         4'h7:    gain_q12 = 14'h10A8;
         4'h8:    gain_q12 = 14'h10C1;
         4'h9:    gain_q12 = 14'h10DA;
         4'hA:    gain_q12 = 14'h10F3;
         default: gain_q12 = GAIN_ONE;
      endcase
   endfunction

   // clip to code range and encode
   function automatic logic [DW-1:0] fmt_word(input logic signed [12:0] v,
                                               input logic twos,
                                               input logic pos,
                                               input logic neg);
      logic signed [12:0] t;
      t = v;
      // RULE_02 positive overdrive code
      if (pos || (t > SAT_POS))
         t = SAT_POS;
      // RULE_03 negative overdrive code
      else if (neg || (t < SAT_NEG))
         t = SAT_NEG;
      // RULE_01 output code format
      fmt_word = twos ? t[DW-1:0] : {~t[DW-1], t[DW-2:0]};
   endfunction

   // synchronisers and link clock edges
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         lk_sync <= 2'h0;
         lk_prev <= 1'b0;
         smp_m   <= '{default: '0};
         smp_q   <= '{default: '0};
         strap_m <= 5'h00;
         strap_q <= 5'h00;
      end
      else
      begin
         lk_sync <= {lk_sync[0], sample_clk};
         lk_prev <= lk_sync[1];
         smp_m   <= '{conv_a, conv_b};
         smp_q   <= smp_m;
         strap_m <= {parallel_cfg_pin, parallel_strap_pin, mode_strap_pins};
         strap_q <= strap_m;
      end
   end

   // register writes and read data
   always_comb
   begin
      next_ctrl   = ctrl;
      next_proc_r = proc_r;
      next_drive  = drive;
      if (reg_wr && (reg_addr == REG_CTRL))
         next_ctrl = reg_wdata & CTRL_MASK;
      if (reg_wr && (reg_addr == REG_PROC))
         next_proc_r = reg_wdata & PROC_MASK;
      if (reg_wr && (reg_addr == REG_DRIVE))
         next_drive = reg_wdata & DRIVE_MASK;
      next_rdata = 16'h0000;
      if (reg_rd)
      begin
         case (reg_addr)
            REG_CTRL:  next_rdata = ctrl;
            REG_PROC:  next_rdata = proc_r;
            REG_DRIVE: next_rdata = drive;
            REG_STAT:  next_rdata = {12'h000, filt_bypass, low_lat, mux_on, fmt_twos};
            REG_OFS_A: next_rdata = {{4{est[0][11]}}, est[0]};
            REG_OFS_B: next_rdata = {{4{est[1][11]}}, est[1]};
            default:   next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         ctrl      <= CTRL_RST;
         // RULE_15 correction off at reset
         proc_r    <= PROC_RST;
         drive     <= DRIVE_RST;
         reg_rdata <= 16'h0000;
      end
      else
      begin
         ctrl      <= next_ctrl;
         proc_r    <= next_proc_r;
         drive     <= next_drive;
         reg_rdata <= next_rdata;
      end
   end

   // effective modes
   always_comb
   begin
      rise     = lk_sync[1] & ~lk_prev;
      fall     = ~lk_sync[1] & lk_prev;
      fmt_twos = strap_q[4] ? strap_q[3] : ctrl[CTRL_TWOS];
      // RULE_07 RULE_08 mux select decode
      mux_req  = strap_q[4] ? (&strap_q[2:0]) : (ctrl[CTRL_PDN +: 3] == PDN_MUX);
      // RULE_04 cmos interface only
      mux_on   = mux_req & ~ctrl[CTRL_LVDS];
      low_lat  = ctrl[CTRL_LLAT];
      // RULE_11 filter bypass flag, read back in status only
      filt_bypass = ctrl[CTRL_NSM] | low_lat;
      dc_en    = proc_r[PROC_DCEN];
      frz      = proc_r[PROC_FRZ];
      // RULE_13 time constant select
      tc_sh    = tc_shift(proc_r[PROC_TC +: 3]);
      // RULE_17 RULE_21 shared gain, unused codes unity
      gain     = (proc_r[PROC_GAIN +: 4] > GAIN_MAXC) ? GAIN_ONE :
                 gain_q12(proc_r[PROC_GAIN +: 4]);
   end

   // datapath, offset loop, latency pipes and output pins
   always_comb
   begin
      logic signed [11:0] s12;
      logic signed [41:0] er;
      logic signed [41:0] lim;
      logic signed [12:0] corr;
      logic signed [26:0] prod;
      logic [DW-1:0]      wp [2];
      logic [DW-1:0]      wl [2];
      logic [DW-1:0]      sel [2];
      s12  = 12'sh000;
      er   = 42'sh0;
      lim  = $signed({30'h0, OFS_LIM});
      corr = 13'sh0;
      prod = 27'sh0;
      wp   = '{default: '0};
      wl   = '{default: '0};
      sel  = '{default: '0};
      next_pipe_n = pipe_n;
      next_pipe_l = pipe_l;
      for (int ch = 0; ch < 2; ch++)
      begin
         s12 = $signed({1'b0, smp_q[ch].code}) - OB_MID;
         // RULE_12 clamped offset estimate
         er  = acc[ch] >>> tc_sh;
         if (er > lim)
            est[ch] = lim[11:0];
         else if (er < -lim)
            est[ch] = 12'(-lim);
         else
            est[ch] = er[11:0];
         next_acc[ch] = acc[ch];
         if (!dc_en)
            next_acc[ch] = 42'sh0;
         // RULE_14 freeze holds estimate
         else if (rise && !frz)
            next_acc[ch] = acc[ch] + 42'(s12) - 42'(est[ch]);
         corr = dc_en ? (13'(s12) - 13'(est[ch])) : 13'(s12);
         // RULE_16 fine gain multiply
         prod = corr * $signed({1'b0, gain});
         // RULE_20 saturate corrected value
         wp[ch] = fmt_word(prod[24:GAIN_FRAC], fmt_twos,
                           smp_q[ch].ovr_pos, smp_q[ch].ovr_neg);
         wl[ch] = fmt_word(13'(s12), fmt_twos, smp_q[ch].ovr_pos, smp_q[ch].ovr_neg);
         // RULE_09 sample latency pipes
         if (rise)
         begin
            for (int i = LAT_N - 1; i > 0; i--)
               next_pipe_n[ch][i] = pipe_n[ch][i-1];
            for (int i = LAT_L - 1; i > 0; i--)
               next_pipe_l[ch][i] = pipe_l[ch][i-1];
            next_pipe_n[ch][0] = wp[ch];
            next_pipe_l[ch][0] = wl[ch];
         end
         // RULE_10 low latency skips processing
         sel[ch] = low_lat ? pipe_l[ch][LAT_L-1] : pipe_n[ch][LAT_N-1];
      end
      next_out_a  = chan_a_out_bus;
      next_out_b  = chan_b_out_bus;
      next_hold_b = hold_b;
      next_stb    = 1'b0;
      // RULE_05 interleave on bus b, bus a off
      next_oe_a   = ~mux_on;
      next_oe_b   = 1'b1;
      if (rise)
      begin
         next_stb = 1'b1;
         if (mux_on)
         begin
            next_out_b  = sel[0];
            next_hold_b = sel[1];
         end
         else
         begin
            next_out_a = sel[0];
            next_out_b = sel[1];
         end
      end
      else if (fall && mux_on)
      begin
         next_stb   = 1'b1;
         next_out_b = hold_b;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         acc            <= '{default: '0};
         pipe_n         <= '{default: '0};
         pipe_l         <= '{default: '0};
         hold_b         <= '0;
         chan_a_out_bus <= '0;
         chan_b_out_bus <= '0;
         chan_a_oe      <= 1'b0;
         chan_b_oe      <= 1'b0;
         out_stb        <= 1'b0;
      end
      else
      begin
         acc            <= next_acc;
         pipe_n         <= next_pipe_n;
         pipe_l         <= next_pipe_l;
         hold_b         <= next_hold_b;
         chan_a_out_bus <= next_out_a;
         chan_b_out_bus <= next_out_b;
         chan_a_oe      <= next_oe_a;
         chan_b_oe      <= next_oe_b;
         out_stb        <= next_stb;
      end
   end

   // buffer drive settings
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         lvds_if_sel  <= 1'b0;
         lvds_cur_sel <= CUR_3P5;
         cur_double   <= 1'b0;
         odt_en       <= 3'h0;
      end
      else
      begin
         lvds_if_sel  <= ctrl[CTRL_LVDS];
         // RULE_18 drive current and doubling
         lvds_cur_sel <= aodp_cur_e'(drive[DRV_CUR +: 2]);
         cur_double   <= drive[DRV_DBL];
         // RULE_19 termination subset
         odt_en       <= drive[DRV_ODT +: 3];
      end
   end

endmodule

// *** bench/aodp_properties.sv ***
// concurrent checks on the output processing block ports
`timescale 1ns/1ps
module aodp_properties
   import aodp_pkg::*;
(
   input wire logic          core_clk,
   input wire logic          resetn,
   input wire logic [3:0]    reg_addr,
   input wire logic [15:0]   reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [15:0]   reg_rdata,
   input wire logic          sample_clk,
   input wire logic          chan_a_oe,
   input wire logic [DW-1:0] chan_b_out_bus,
   input wire logic          chan_b_oe,
   input wire logic          out_stb,
   input wire logic          lvds_if_sel,
   input wire aodp_cur_e     lvds_cur_sel,
   input wire logic          cur_double,
   input wire logic [2:0]    odt_en
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   sequence drv_wr;
      reg_wr && reg_addr == REG_DRIVE ##2 1'b1;
   endsequence
   sequence ctl_wr;
      reg_wr && reg_addr == REG_CTRL ##2 1'b1;
   endsequence
   drive_set_a: assert property (
      drv_wr |-> {odt_en, cur_double, lvds_cur_sel} == $past(reg_wdata[5:0], 2))
      else $error("drive outputs differ from written value");
   iface_sel_a: assert property (
      ctl_wr |-> lvds_if_sel == $past(reg_wdata[CTRL_LVDS], 2))
      else $error("interface select differs from written value");
   no_mux_a: assert property (
      lvds_if_sel [*4] |-> chan_a_oe)
      else $error("bus a released with ddr interface");
   b_drive_a: assert property (
      $past(resetn) |-> chan_b_oe)
      else $error("bus b not driven");
   stb_pulse_a: assert property (
      out_stb |=> !out_stb [*3])
      else $error("strobe too long or too close");
   stb_rise_a: assert property (
      $rose(sample_clk) |-> ##[2:8] out_stb)
      else $error("no word after sample edge");
   word_stand_a: assert property (
      !out_stb |-> $stable(chan_b_out_bus))
      else $error("bus b changed without strobe");
   rd_idle_a: assert property (
      !$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
endmodule
bind aodp_top aodp_properties aodp_properties_i (.*);

// *** bench/aodp_rx_model.sv ***
// receiving device model that captures output words
`timescale 1ns/1ps
module aodp_rx_model
   import aodp_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          resetn,
   input  wire logic          out_stb,
   input  wire logic [DW-1:0] chan_a_out_bus,
   input  wire logic          chan_a_oe,
   input  wire logic [DW-1:0] chan_b_out_bus,
   output logic      [DW-1:0] word_a,
   output logic      [DW-1:0] word_b,
   output logic      [7:0]    word_cnt
);
   logic [DW-1:0] a_pin;
   assign a_pin = chan_a_oe ? chan_a_out_bus : ~word_a;
   always @(posedge core_clk)
      if (!resetn)
      begin
         word_a <= '0;
         word_b <= '0;
         word_cnt <= '0;
      end
      else if (out_stb)
      begin
         word_a <= a_pin;
         word_b <= chan_b_out_bus;
         word_cnt <= word_cnt + 8'h01;
      end
endmodule

// *** bench/aodp_top_tb.sv ***
// self-checking bench of the output processing block
`timescale 1ns/1ps
module aodp_top_tb
   import aodp_pkg::*;
;
   logic          core_clk, resetn, reg_wr, reg_rd, sample_clk, chan_a_oe, chan_b_oe;
   logic          out_stb, lvds_if_sel, cur_double, tw, ll, nsm, st, ok;
   logic          parallel_cfg_pin, parallel_strap_pin;
   logic [2:0]    mode_strap_pins, odt_en;
   logic [3:0]    reg_addr, g;
   logic [15:0]   reg_wdata, reg_rdata, v;
   logic [DW-1:0] chan_a_out_bus, chan_b_out_bus, word_a, word_b, w1, w2, ea, eb;
   logic [7:0]    word_cnt;
   aodp_cur_e     lvds_cur_sel;
   aodp_smp_s     conv_a, conv_b, a, b;
   int            n_errors = 0;
   int            n_compared = 0;
   int            gt[11] = '{4096, 4120, 4143, 4167, 4191, 4216, 4240, 4264, 4289, 4314, 4339};
   aodp_top aodp_top_i (.*);
   aodp_rx_model aodp_rx_model_i (.*);
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial
   begin
      sample_clk = 1'b0;
      #7;
      forever #80 sample_clk = ~sample_clk;
   end
   task test_done;
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task wr(logic [3:0] ad, logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(logic [3:0] ad);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task settle(int n);
      repeat (n) @(posedge sample_clk);
      repeat (6) @(posedge core_clk);
   endtask
   task put(aodp_smp_s pa, aodp_smp_s pb);
      @(negedge sample_clk);
      @(posedge core_clk);
      conv_a <= pa;
      conv_b <= pb;
   endtask
   task cfg(logic ftw, fll, fns, fst, logic [2:0] pdn, logic [3:0] fg);
      @(posedge core_clk);
      parallel_cfg_pin <= fst;
      parallel_strap_pin <= ftw;
      mode_strap_pins <= pdn;
      wr(REG_CTRL, {9'h000, fst ? 3'h0 : pdn, fns, fll, 1'b0, ftw ^ fst});
      wr(REG_PROC, {12'h000, fg});
   endtask
   task nxt(output logic [DW-1:0] w);
      logic [7:0] c;
      c = word_cnt;
      for (int k = 0; k < 40 && word_cnt == c; k++)
      begin
         @(posedge core_clk);
         #1;
      end
      w = word_b;
   endtask
   function aodp_smp_s rsmp(int k);
      aodp_smp_s s;
      s.code = DW'($urandom);
      s.ovr_pos = (k == 1);
      s.ovr_neg = (k == 2);
      return s;
   endfunction
   function logic [10:0] expw(aodp_smp_s c, logic ftw, logic byp, logic [3:0] fg);
      int y;
      y = int'(c.code) - 1024;
      if (!byp)
         y = (y * (fg > 4'hA ? 4096 : gt[fg])) >>> 12;
      if (y > 1023 || c.ovr_pos)
         y = 1023;
      if (y < -1024 || c.ovr_neg)
         y = -1024;
      return {y[10] ^ !ftw, y[9:0]};
   endfunction
   initial
   begin
      {resetn, reg_wr, reg_rd, parallel_cfg_pin, parallel_strap_pin} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      mode_strap_pins = '0;
      conv_a = '0;
      conv_b = '0;
      void'($urandom(83766));
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         rd(4'(i));
         chk("reset read", v, 16'h0000);
      end
      wr(REG_PROC, 16'hFFFF);
      rd(REG_PROC);
      chk("proc mask", v, PROC_MASK);
      for (int i = 0; i < 64; i++)
      begin
         wr(REG_DRIVE, 16'(i));
         @(posedge core_clk);
         #1 chk("drive", {10'h000, odt_en, cur_double, lvds_cur_sel}, 16'(i));
      end
      for (int i = 0; i < 24; i++)
      begin
         tw = 1'($urandom);
         ll = 1'($urandom);
         nsm = 1'($urandom);
         st = 1'($urandom);
         g = 4'($urandom);
         a = rsmp(i < 6 ? i % 3 : 0);
         b = rsmp(i < 6 ? (i + 1) % 3 : 0);
         if (i == 6)
         begin
            a.code = 11'h7FF;
            b.code = 11'h000;
            g = 4'hA;
            ll = 1'b0;
         end
         cfg(tw, ll, nsm, st, 3'($urandom % 7), g);
         put(a, b);
         settle(16);
         chk("word a", 16'(word_a), 16'(expw(a, tw, ll, g)));
         chk("word b", 16'(word_b), 16'(expw(b, tw, ll, g)));
         rd(REG_STAT);
         chk("status", v, {12'h0, nsm | ll, ll, 1'b0, tw});
      end
      for (int k = 0; k < 2; k++)
      begin
         cfg(1'b0, 1'(k), 1'b0, 1'b0, 3'h0, 4'h0);
         a = rsmp(0);
         put(a, a);
         settle(16);
         b = a;
         b.code = ~a.code;
         put(b, b);
         settle(k ? LAT_LOW : LAT_NORM);
         chk("early", 16'(chan_b_out_bus), 16'(expw(a, 1'b0, 1'(k), 4'h0)));
         settle(1);
         chk("late", 16'(chan_b_out_bus), 16'(expw(b, 1'b0, 1'(k), 4'h0)));
      end
      cfg(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 4'h0);
      a = rsmp(0);
      a.code = 11'h3FF;
      put(a, a);
      settle(2);
      wr(REG_PROC, 16'h00B0);
      settle(16);
      a.code = 11'h400;
      chk("offset word", 16'(word_b), 16'(expw(a, 1'b0, 1'b0, 4'h0)));
      rd(REG_OFS_A);
      chk("offset a", v, 16'hFFFF);
      wr(REG_PROC, 16'h01B0);
      b = rsmp(0);
      b.code = {1'b1, b.code[9:1], 1'b0};
      put(b, b);
      settle(16);
      b.code = b.code + 11'h001;
      chk("frozen word", 16'(word_b), 16'(expw(b, 1'b0, 1'b0, 4'h0)));
      rd(REG_OFS_B);
      chk("frozen offset", v, 16'hFFFF);
      for (int k = 0; k < 3; k++)
      begin
         cfg(1'b1, 1'b0, 1'b0, 1'(k == 1), 3'h7, 4'h0);
         if (k == 2)
            wr(REG_CTRL, 16'h0073);
         a = rsmp(0);
         b = rsmp(0);
         b.code = ~a.code;
         ea = expw(a, 1'b1, 1'b0, 4'h0);
         eb = expw(b, 1'b1, 1'b0, 4'h0);
         put(a, b);
         settle(16);
         chk("a enable", 16'(chan_a_oe), 16'(k == 2));
         nxt(w1);
         nxt(w2);
         ok = (k == 2) ? (w1 === eb && w2 === eb) :
              ((w1 === ea && w2 === eb) || (w1 === eb && w2 === ea));
         chk("bus b words", 16'(ok), 16'h0001);
         rd(REG_STAT);
         chk("mux status", v & 16'h2, {14'h0, k != 2, 1'b0});
      end
      test_done;
   end
   initial
   begin
      #1000000;
      n_errors++;
      test_done;
   end
endmodule
